/* File: ccsh_defs.svh */
// Constants for the channel command and status handler.
// Assumes inclusion by bare name from the package and the modules.
`ifndef CCSH_DEFS_SVH
`define CCSH_DEFS_SVH
// Device addresses and the control unit address
`define CCSH_NDEV          4
`define CCSH_DEV_CU        2'h0
// Channel command codes
`define CCSH_CMD_TIO       8'h00
`define CCSH_CMD_WRITE     8'h01
`define CCSH_CMD_READ      8'h02
`define CCSH_CMD_NOP       8'h03
`define CCSH_CMD_SENSE     8'h04
`define CCSH_CMD_SENSE_ID  8'hE4
`define CCSH_CMD_SET_STOP  8'h0B
`define CCSH_CMD_SET_START 8'h0F
`define CCSH_CMD_SET_ADDR  8'h13
// Start register values
`define CCSH_START_WORD    16'h0001
`define CCSH_START_BYTE    16'h0002
// Address register regions
`define CCSH_ADDR_CS_BASE  16'hF000
`define CCSH_ADDR_BUF_LIM  16'h1000
// Error register bits
`define CCSH_ERR_INT_PAR   0
`define CCSH_ERR_BUSOUT    1
// Retry limit and disable debounce
`define CCSH_RETRY_LIMIT   5'h14
`define CCSH_DIS_TIME_NS   100
`define CCSH_CLK_NS        5
`define CCSH_DIS_CYC       ((`CCSH_DIS_TIME_NS + `CCSH_CLK_NS - 1) / `CCSH_CLK_NS)
// Register map (byte addresses)
`define CCSH_REG_CTRL      12'h000
`define CCSH_REG_STATUS    12'h004
`define CCSH_REG_MODE      12'h008
`define CCSH_REG_SENSE     12'h00C
`define CCSH_REG_RETRY     12'h010
`define CCSH_REG_ERR       12'h014
`endif

/* File: ccsh_pkg.sv */
// Types for the channel command and status handler.
// Assumes ccsh_defs.svh is on the include path.
`include "ccsh_defs.svh"
package ccsh_pkg;
  // Decoded command class
  typedef enum logic [9:0] {
    CCSH_C_TIO     = 10'h001,
    CCSH_C_WRITE   = 10'h002,
    CCSH_C_READ    = 10'h004,
    CCSH_C_NOP     = 10'h008,
    CCSH_C_SENSE   = 10'h010,
    CCSH_C_SENSEID = 10'h020,
    CCSH_C_STOP    = 10'h040,
    CCSH_C_START   = 10'h080,
    CCSH_C_ADDR    = 10'h100,
    CCSH_C_BAD     = 10'h200
  } ccsh_cmd_t;
  // Route of a read or write
  typedef enum logic [2:0] {
    CCSH_RT_CS  = 3'h1,
    CCSH_RT_CU  = 3'h2,
    CCSH_RT_BUF = 3'h4
  } ccsh_route_t;
  // Status byte bits
  typedef struct packed {
    logic busy;
    logic unit_check;
    logic device_end;
    logic channel_end;
  } ccsh_status_t;
  // Main controller states
  typedef enum logic [3:0] {
    CCSH_S_ONLINE  = 4'h1,
    CCSH_S_GOOFF   = 4'h2,
    CCSH_S_DISABLE = 4'h4,
    CCSH_S_OFFLINE = 4'h8
  } ccsh_state_t;
endpackage

/* File: ccsh_dec_if.sv */
// Interface between the command decoder and the handler.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface ccsh_dec_if;
  import ccsh_pkg::*;
  logic [7:0]  opcode;
  logic [15:0] addr_reg;
  logic [1:0]  dev;
  ccsh_cmd_t   cmd;
  ccsh_route_t route;
  logic        addr_bad;
  modport dec (input opcode, addr_reg, dev, output cmd, route, addr_bad);
  modport ctl (output opcode, addr_reg, dev, input cmd, route, addr_bad);
endinterface
`default_nettype wire

/* File: ccsh_decoder.sv */
// Combinational command decoder and read/write router.
// Assumes operands held stable by the handler.
`timescale 1ns/1ps
`default_nettype none
`include "ccsh_defs.svh"
module ccsh_decoder
  import ccsh_pkg::*;
(
  ccsh_dec_if.dec d
);
  // ----------------------------------------
  // Opcode and route decode
  // ----------------------------------------
  always_comb begin
    case (d.opcode)
      `CCSH_CMD_TIO:       d.cmd = CCSH_C_TIO; // R21
      `CCSH_CMD_WRITE:     d.cmd = CCSH_C_WRITE;
      `CCSH_CMD_READ:      d.cmd = CCSH_C_READ;
      `CCSH_CMD_NOP:       d.cmd = CCSH_C_NOP;
      `CCSH_CMD_SENSE:     d.cmd = CCSH_C_SENSE;
      `CCSH_CMD_SENSE_ID:  d.cmd = CCSH_C_SENSEID;
      `CCSH_CMD_SET_STOP:  d.cmd = CCSH_C_STOP;
      `CCSH_CMD_SET_START: d.cmd = CCSH_C_START;
      `CCSH_CMD_SET_ADDR:  d.cmd = CCSH_C_ADDR;
      default:             d.cmd = CCSH_C_BAD;
    endcase
    // Control space first, then control unit, then buffer
    if (d.addr_reg >= `CCSH_ADDR_CS_BASE) begin
      d.route = CCSH_RT_CS; // R14
    end else if (d.dev == `CCSH_DEV_CU) begin
      d.route = CCSH_RT_CU; // R14
    end else begin
      d.route = CCSH_RT_BUF; // R14
    end
    // Buffer addresses beyond the buffer are invalid
    d.addr_bad = (d.route == CCSH_RT_BUF) && (d.addr_reg >= `CCSH_ADDR_BUF_LIM); // R15
  end
endmodule
`default_nettype wire

/* File: ccsh_apb.sv */
// APB slave holding the software-visible control and status words.
// Assumes a single-cycle APB master; answers with zero wait states.
`timescale 1ns/1ps
`default_nettype none
`include "ccsh_defs.svh"
module ccsh_apb
  import ccsh_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [31:0] stat_word_in,
  input  wire logic [31:0] mode_word_in,
  input  wire logic [31:0] sense_word_in,
  input  wire logic [31:0] retry_word_in,
  input  wire logic [31:0] err_word_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             restart_out
);
  typedef struct packed {
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        restart;
  } ccsh_apb_st_t;
  ccsh_apb_st_t st_r;
  ccsh_apb_st_t st_nxt;
  // ----------------------------------------
  // Decode one access per setup cycle
  // ----------------------------------------
  always_comb begin
    st_nxt = '0;
    if (psel_in && !penable_in) begin
      st_nxt.ready = 1'b1;
      case (paddr_in)
        `CCSH_REG_CTRL:   st_nxt.restart = pwrite_in & pwdata_in[0];
        `CCSH_REG_STATUS: st_nxt.rdata = stat_word_in;
        `CCSH_REG_MODE:   st_nxt.rdata = mode_word_in;
        `CCSH_REG_SENSE:  st_nxt.rdata = sense_word_in;
        `CCSH_REG_RETRY:  st_nxt.rdata = retry_word_in;
        `CCSH_REG_ERR:    st_nxt.rdata = err_word_in;
        default:          st_nxt.err = 1'b1;
      endcase
    end
  end
  // State register
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign prdata_out  = st_r.rdata;
  assign pready_out  = st_r.ready;
  assign pslverr_out = st_r.err;
  assign restart_out = st_r.restart;
endmodule
`default_nettype wire

/* File: ccsh_top.sv */
// Channel command and status handler: decodes channel commands per
// device address, answers with status and keeps sense and mode bits.
// Assumes channel strobes are one-cycle pulses synchronous to clock_in.
//
// Behaviour
// R1: Twenty adapter parity retries take unit off-line
// R2: Selective reset ends activity until acknowledged
// R3: Disable switch refuses all channel traffic
// R4: Selective reset to not-ready device ignored
// R5: Interrupt during off-line sequence served first
// R6: Short disable glitch ignored, stay on-line
// R7: Off-line after error ignores stimuli until restart
// R8: Error register bits classify transfer errors
// R9: Transfer error gives unit check, updates sense; code sets the error register class, not the sense bits
// R10: Start value 0001 selects word mode
// R11: Start value 0002 selects byte mode
// R12: Command with error: reject, unit check if idle
// R13: Unsupported command: unit check, command reject
// R14: Read/write routed control space, unit, buffer
// R15: Invalid address register: unit check, reject
// R16: Busy device answers busy initial status
// R17: Pending status answers busy initial status
// R18: Not-ready device accepts only sense
// R19: Memory parity with new command discarded
// R20: Lone causeless error interrupt ignored
// R21: Decoder knows the nine channel commands
// R22: Command reject cleared by sense read
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ccsh_defs.svh"
module ccsh_top
  import ccsh_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  // Channel side
  input  wire logic        new_command_interrupt_in,
  input  wire logic [1:0]  dev_addr_in,
  input  wire logic [7:0]  opcode_in,
  input  wire logic [15:0] cmd_data_in,
  input  wire logic        cmd_error_in,
  input  wire logic        mem_parity_in,
  input  wire logic        sel_reset_in,
  input  wire logic        adapter_parity_in,
  input  wire logic        error_irq_in,
  input  wire logic        xfer_error_in,
  input  wire logic        xfer_to_host_in,
  input  wire logic [6:0]  error_reg_in,
  input  wire logic        disable_sw_in,

  // Device side
  input  wire logic [3:0]  dev_busy_in,
  input  wire logic [3:0]  dev_ready_in,
  input  wire logic [3:0]  status_pend_in,
  input  wire logic [3:0]  reset_ack_in,

  // APB
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,

  // Answers
  output logic             status_valid_out,
  output logic [3:0]       status_out,
  output logic [1:0]       status_dev_out,
  output logic             route_valid_out,
  output logic [2:0]       route_out,
  output logic [3:0]       sel_reset_notify_out,
  output logic [3:0]       word_mode_out,
  output logic [3:0]       cmd_reject_out,
  output logic             online_out
);
  typedef struct packed {
    ccsh_state_t  state;
    logic [4:0]   retries;
    logic [7:0]   dis_cnt;
    logic [3:0]   resetting;
    logic [3:0]   word_mode;
    logic [3:0]   reject;
    logic [15:0]  addr_reg;
    logic [2:0]   err_class;
    logic         err_off;
    logic         st_valid;
    ccsh_status_t st;
    logic [1:0]   st_dev;
    logic         rt_valid;
    logic [2:0]   rt;
  } ccsh_st_t;
  ccsh_st_t st_r;
  ccsh_st_t st_nxt;
  logic       restart;

  ccsh_dec_if dec_if ();
  assign dec_if.opcode   = opcode_in;
  assign dec_if.addr_reg = st_r.addr_reg;
  assign dec_if.dev      = dev_addr_in;
  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  ccsh_decoder u_dec (
    .d (dec_if.dec)
  );

  ccsh_apb u_apb (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .psel_in       (psel_in),
    .penable_in    (penable_in),
    .pwrite_in     (pwrite_in),
    .paddr_in      (paddr_in),
    .pwdata_in     (pwdata_in),
    .stat_word_in  ({28'h0000000, st_r.state}),
    .mode_word_in  ({28'h0000000, st_r.word_mode}),
    .sense_word_in ({28'h0000000, st_r.reject}),
    .retry_word_in ({27'h0000000, st_r.retries}),
    .err_word_in   ({28'h0000000, st_r.err_off, st_r.err_class}),
    .prdata_out    (prdata_out),
    .pready_out    (pready_out),
    .pslverr_out   (pslverr_out),
    .restart_out   (restart)
  );
  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic       chan_act;
  logic       dev_rdy;
  logic       dev_rst;
  logic       cmd_ok;
  always_comb begin
    st_nxt          = st_r;
    st_nxt.st_valid = 1'b0;
    st_nxt.st       = '0;
    st_nxt.rt_valid = 1'b0;
    dev_rdy  = dev_ready_in[dev_addr_in];
    // A reset in progress holds off commands to every address
    dev_rst  = |st_r.resetting; // R2
    chan_act = (st_r.state == CCSH_S_ONLINE) || (st_r.state == CCSH_S_GOOFF); // R3 R5 R7
    cmd_ok   = 1'b0;

    // Resets clear when their handler acknowledges
    st_nxt.resetting = st_r.resetting & ~reset_ack_in; // R2

    // Parity retry count, cleared by reset and by restart, held at the limit
    if (adapter_parity_in && st_r.retries != `CCSH_RETRY_LIMIT) begin
      st_nxt.retries = st_r.retries + 5'h01; // R1
    end

    // Controller states
    case (st_r.state)
      CCSH_S_ONLINE: begin
        if (disable_sw_in) begin
          st_nxt.dis_cnt = st_r.dis_cnt + 8'h01;
          if (st_r.dis_cnt == 8'(`CCSH_DIS_CYC - 1)) begin
            st_nxt.state = CCSH_S_GOOFF;
          end
        end else begin
          st_nxt.dis_cnt = 8'h00; // R6
        end
      end
      CCSH_S_GOOFF: begin
        // Finish only when no channel interrupt waits
        if (!new_command_interrupt_in && !sel_reset_in) begin
          st_nxt.state = CCSH_S_DISABLE; // R5
        end
      end
      CCSH_S_DISABLE: begin
        if (!disable_sw_in) begin
          st_nxt.state   = CCSH_S_ONLINE;
          st_nxt.dis_cnt = 8'h00;
        end
      end
      CCSH_S_OFFLINE: begin
        if (restart) begin
          st_nxt.state   = CCSH_S_ONLINE; // R7
          // Fresh retry tally, else the limit trips again at once
          st_nxt.retries = 5'h00; // R1
          st_nxt.err_off = 1'b0;
          st_nxt.dis_cnt = 8'h00;
        end
      end
      default: st_nxt.state = CCSH_S_OFFLINE;
    endcase
    if (st_r.retries == `CCSH_RETRY_LIMIT && st_r.state != CCSH_S_OFFLINE && !st_r.err_off) begin
      st_nxt.state   = CCSH_S_OFFLINE; // R1
      st_nxt.err_off = 1'b1;
    end

    // Selective reset, ignored for not-ready devices
    if (chan_act && sel_reset_in && dev_rdy) begin
      st_nxt.resetting[dev_addr_in] = 1'b1; // R2 R4
    end

    // Transfer error classification and unit check
    if (chan_act && xfer_error_in) begin
      if (xfer_to_host_in && error_reg_in[`CCSH_ERR_INT_PAR]) begin
        st_nxt.err_class = 3'h1; // R8
      end else if (!xfer_to_host_in && error_reg_in[`CCSH_ERR_BUSOUT]) begin
        st_nxt.err_class = 3'h2; // R8
      end else begin
        st_nxt.err_class = 3'h4; // R8
      end
      st_nxt.st_valid      = 1'b1;
      st_nxt.st.unit_check = 1'b1; // R9
      st_nxt.st_dev        = dev_addr_in;
    end

    // Lone error interrupt with no cause: nothing happens
    if (error_irq_in && !xfer_error_in && !cmd_error_in) begin
      st_nxt.err_class = st_nxt.err_class; // R20
    end

    // New command handling
    if (chan_act && new_command_interrupt_in && !dev_rst && !xfer_error_in) begin
      st_nxt.st_valid = 1'b1;
      st_nxt.st_dev   = dev_addr_in;
      // Memory parity with a command is spurious and not looked at
      if (cmd_error_in) begin
        st_nxt.reject[dev_addr_in] = 1'b1; // R12
        st_nxt.st.unit_check = !status_pend_in[dev_addr_in]; // R12
        st_nxt.st.busy       = status_pend_in[dev_addr_in];
      end else if (dev_busy_in[dev_addr_in]) begin
        st_nxt.st.busy = 1'b1; // R16
      end else if (status_pend_in[dev_addr_in]) begin
        st_nxt.st.busy = 1'b1; // R17
      end else if (!dev_rdy && dec_if.cmd != CCSH_C_SENSE) begin
        st_nxt.st.unit_check = 1'b1; // R18
        st_nxt.reject[dev_addr_in] = 1'b1;
      end else if (dec_if.cmd == CCSH_C_BAD) begin
        st_nxt.st.unit_check = 1'b1; // R13
        st_nxt.reject[dev_addr_in] = 1'b1;
      end else if ((dec_if.cmd == CCSH_C_READ || dec_if.cmd == CCSH_C_WRITE)
                   && dec_if.addr_bad) begin
        st_nxt.st.unit_check = 1'b1; // R15
        st_nxt.reject[dev_addr_in] = 1'b1;
      end else begin
        cmd_ok = 1'b1; // R19
      end
      if (cmd_ok) begin
        st_nxt.st.channel_end = 1'b1;
        st_nxt.st.device_end  = 1'b1;
        case (dec_if.cmd)
          CCSH_C_READ, CCSH_C_WRITE: begin
            st_nxt.rt_valid = 1'b1;
            st_nxt.rt       = dec_if.route; // R14
          end
          CCSH_C_SENSE: st_nxt.reject[dev_addr_in] = 1'b0; // R22
          CCSH_C_ADDR:  st_nxt.addr_reg = cmd_data_in;
          CCSH_C_START: begin
            if (cmd_data_in == `CCSH_START_WORD) begin
              st_nxt.word_mode[dev_addr_in] = 1'b1; // R10
            end else if (cmd_data_in == `CCSH_START_BYTE) begin
              st_nxt.word_mode[dev_addr_in] = 1'b0; // R11
            end else begin
              st_nxt.st.unit_check = 1'b1;
            end
          end
          default: st_nxt.rt = st_r.rt;
        endcase
      end
    end
  end
  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st_r       <= '0;
      st_r.state <= CCSH_S_ONLINE;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign status_valid_out     = st_r.st_valid;
  assign status_out           = st_r.st;
  assign status_dev_out       = st_r.st_dev;
  assign route_valid_out      = st_r.rt_valid;
  assign route_out            = st_r.rt;
  assign sel_reset_notify_out = st_r.resetting;
  assign word_mode_out        = st_r.word_mode;
  assign cmd_reject_out       = st_r.reject;
  assign online_out           = st_r.state[0];
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_RETRY_OFF: assert property (@(posedge clock_in) disable iff (srst_in) // R1
    (st_r.retries == `CCSH_RETRY_LIMIT && !st_r.err_off) |=> st_r.state == CCSH_S_OFFLINE)
    else $error("retry limit did not go off-line");

  AST_RESET_HOLD: assert property (@(posedge clock_in) disable iff (srst_in) // R2
    (st_r.resetting[1] && !reset_ack_in[1]) |=> st_r.resetting[1])
    else $error("selective reset dropped without acknowledge");

  AST_DISABLED_QUIET: assert property (@(posedge clock_in) disable iff (srst_in) // R3
    (st_r.state == CCSH_S_DISABLE) |=> !st_r.st_valid)
    else $error("status while disabled");

  AST_NOTREADY_RESET: assert property (@(posedge clock_in) disable iff (srst_in) // R4
    (sel_reset_in && dev_addr_in == 2'h2 && !dev_ready_in[2] && !st_r.resetting[2])
    |=> !st_r.resetting[2])
    else $error("reset taken for not-ready device");

  AST_GLITCH: assert property (@(posedge clock_in) disable iff (srst_in) // R6
    (st_r.state == CCSH_S_ONLINE && !disable_sw_in && st_r.retries != `CCSH_RETRY_LIMIT)
    |=> st_r.state == CCSH_S_ONLINE)
    else $error("left on-line without held disable");

  AST_OFF_QUIET: assert property (@(posedge clock_in) disable iff (srst_in) // R7
    (st_r.state == CCSH_S_OFFLINE) |=> !st_r.st_valid && !st_r.rt_valid)
    else $error("answer while off-line");

  AST_WORD: assert property (@(posedge clock_in) disable iff (srst_in) // R10
    (st_r.st_valid && $past(cmd_ok) && $past(dec_if.cmd) == CCSH_C_START
     && $past(cmd_data_in) == `CCSH_START_WORD) |-> st_r.word_mode[st_r.st_dev])
    else $error("word mode not set");

  AST_BAD_CMD: assert property (@(posedge clock_in) disable iff (srst_in) // R13
    (chan_act && new_command_interrupt_in && opcode_in == 8'h55 && dev_ready_in[dev_addr_in]
     && !dev_busy_in[dev_addr_in] && !status_pend_in[dev_addr_in] && !cmd_error_in
     && !xfer_error_in && st_r.resetting == 4'h0)
    |=> st_r.st.unit_check && st_r.reject[st_r.st_dev])
    else $error("bad command not rejected");

  AST_BUSY: assert property (@(posedge clock_in) disable iff (srst_in) // R16
    (chan_act && new_command_interrupt_in && dev_busy_in[dev_addr_in] && !cmd_error_in
     && !xfer_error_in && st_r.resetting == 4'h0) |=> st_r.st.busy)
    else $error("busy device not answered busy");

  AST_PENDING: assert property (@(posedge clock_in) disable iff (srst_in) // R17
    (chan_act && new_command_interrupt_in && status_pend_in[dev_addr_in] && !cmd_error_in
     && !xfer_error_in && st_r.resetting == 4'h0) |=> st_r.st.busy)
    else $error("pending status not answered busy");

  COV_ROUTE: cover property (@(posedge clock_in) st_r.rt_valid);
  COV_GOOFF: cover property (@(posedge clock_in) st_r.state == CCSH_S_GOOFF);
  COV_OFF: cover property (@(posedge clock_in) st_r.state == CCSH_S_OFFLINE);
  COV_DIS: cover property (@(posedge clock_in) st_r.state == CCSH_S_DISABLE);
  COV_REJ: cover property (@(posedge clock_in) st_r.st.unit_check);
endmodule
`default_nettype wire

/* File: ccsh_chan_model.sv */
// Host channel model: turns bench requests into command and reset strobes,
// and keeps the last status that the handler presents.
// Assumes one clock and one-cycle status pulses from the handler.
`timescale 1ns/1ps
`default_nettype none
module ccsh_chan_model (
  input  wire logic        clock_in,
  input  wire logic        go_in,
  input  wire logic        sr_in,
  input  wire logic [1:0]  dev_in,
  input  wire logic [7:0]  op_in,
  input  wire logic [15:0] data_in,
  input  wire logic        status_valid_in,
  input  wire logic [3:0]  status_in,
  output logic             cmd_out,
  output logic             sel_reset_out,
  output logic [1:0]       dev_out,
  output logic [7:0]       op_out,
  output logic [15:0]      data_out,
  output logic [3:0]       status_out,
  output logic [7:0]       count_out
);
  // Quiet lines at time zero
  initial begin
    {cmd_out, sel_reset_out, dev_out, op_out, data_out, status_out, count_out} = '0;
  end
  // One-cycle strobes; released opcode and data lines flip every cycle so stale values never match, device lines hold
  always @(posedge clock_in) begin
    cmd_out <= go_in;
    sel_reset_out <= sr_in;
    if (go_in || sr_in) begin
      dev_out <= dev_in;
      op_out <= op_in;
      data_out <= data_in;
    end else begin
      op_out <= ~op_out;
      data_out <= ~data_out;
    end
    if (status_valid_in) begin
      status_out <= status_in;
      count_out <= count_out + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* File: channel_command_status_handler_bench.sv */
// Self-checking bench for the channel command and status handler.
// Assumes the design files and the host channel model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ccsh_defs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %0h expected %0h", $time, (a), (b)); end end
module channel_command_status_handler_bench;
  import ccsh_pkg::*;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        clk = 1'b0, srst = 1'b1, go = 1'b0, sr = 1'b0, cerr = 1'b0, mpar = 1'b0;
  logic        apar = 1'b0, eirq = 1'b0, xerr = 1'b0, xth = 1'b0, dis = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, rerr, pready, pslverr, sv, rv, online;
  logic [6:0]  ereg = 7'h00;
  logic [3:0]  busy = 4'h0, rdy = 4'hF, pend = 4'h0, ack = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata, prdata;
  logic [1:0]  dev = 2'h0, sdev, mdev;
  logic [7:0]  op = 8'h00, mop, scnt, c0;
  logic [15:0] cdata = 16'h0000, mdata;
  logic [3:0]  st, notify, wmode, crej, lstat;
  logic [2:0]  rt, lroute = 3'h0;
  logic        ncmd, msr;
  int          error_cnt = 0, comparisons = 0, k;
  logic [7:0]  ops [9] = '{`CCSH_CMD_TIO, `CCSH_CMD_WRITE, `CCSH_CMD_READ, `CCSH_CMD_NOP,
    `CCSH_CMD_SENSE, `CCSH_CMD_SENSE_ID, `CCSH_CMD_SET_STOP, `CCSH_CMD_SET_START,
    `CCSH_CMD_SET_ADDR};

  ccsh_top i_dut (.clock_in(clk), .srst_in(srst), .new_command_interrupt_in(ncmd),
    .dev_addr_in(mdev), .opcode_in(mop), .cmd_data_in(mdata), .cmd_error_in(cerr),
    .mem_parity_in(mpar), .sel_reset_in(msr), .adapter_parity_in(apar), .error_irq_in(eirq),
    .xfer_error_in(xerr), .xfer_to_host_in(xth), .error_reg_in(ereg), .disable_sw_in(dis),
    .dev_busy_in(busy), .dev_ready_in(rdy), .status_pend_in(pend), .reset_ack_in(ack),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .status_valid_out(sv), .status_out(st), .status_dev_out(sdev), .route_valid_out(rv),
    .route_out(rt), .sel_reset_notify_out(notify), .word_mode_out(wmode),
    .cmd_reject_out(crej), .online_out(online));
  ccsh_chan_model i_chan (.clock_in(clk), .go_in(go), .sr_in(sr), .dev_in(dev),
    .op_in(op), .data_in(cdata), .status_valid_in(sv), .status_in(st), .cmd_out(ncmd),
    .sel_reset_out(msr), .dev_out(mdev), .op_out(mop), .data_out(mdata),
    .status_out(lstat), .count_out(scnt));

  // Clock and route capture
  always #2.5 clk = ~clk;
  always @(posedge clk) if (rv) lroute <= rt;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // APB transfer: setup, access held until pready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin error_cnt++; stop_test(); end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask
  // Channel command; x = {memory parity, command error}, n = status expected
  task automatic cmd(input logic [1:0] d, input logic [7:0] o, input logic [15:0] v,
                     input logic [1:0] x, input logic n, input logic [1:0] bu);
    c0 = scnt;
    go <= 1'b1; dev <= d; op <= o; cdata <= v;
    @(posedge clk) go <= 1'b0;
    cerr <= x[0]; mpar <= x[1];
    @(posedge clk) cerr <= 1'b0;
    mpar <= 1'b0;
    tick(3);
    `CHK(scnt - c0, {7'h00, n})
    if (n) `CHK({lstat[3:2], sdev}, {bu, d})
  endtask
  task automatic sreset(input logic [1:0] d);
    sr <= 1'b1; dev <= d;
    @(posedge clk) sr <= 1'b0;
    tick(3);
  endtask
  task automatic rst;
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    tick(1);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    rst();
    `CHK({online, crej, wmode}, 9'h100)
    for (k = 0; k < 9; k++) cmd(2'h1, ops[k], 16'h0001, 2'h0, 1'b1, 2'h0);
    `CHK(lroute, 3'h4)
    `CHK(wmode[1], 1'b1)
    cmd(2'h1, `CCSH_CMD_SET_START, 16'h0002, 2'h0, 1'b1, 2'h0);
    `CHK(wmode[1], 1'b0)
    cmd(2'h1, `CCSH_CMD_SET_ADDR, 16'hF000, 2'h0, 1'b1, 2'h0);
    cmd(2'h1, `CCSH_CMD_WRITE, 16'h0000, 2'h0, 1'b1, 2'h0);
    `CHK(lroute, 3'h1)
    cmd(2'h0, `CCSH_CMD_SET_ADDR, 16'h0000, 2'h0, 1'b1, 2'h0);
    cmd(2'h0, `CCSH_CMD_READ, 16'h0000, 2'h0, 1'b1, 2'h0);
    `CHK(lroute, 3'h2)
    cmd(2'h1, `CCSH_CMD_SET_ADDR, 16'h2000, 2'h0, 1'b1, 2'h0);
    cmd(2'h1, `CCSH_CMD_READ, 16'h0000, 2'h0, 1'b1, 2'h1);
    `CHK(crej[1], 1'b1)
    cmd(2'h1, `CCSH_CMD_SENSE, 16'h0000, 2'h0, 1'b1, 2'h0);
    `CHK(crej[1], 1'b0)
    $display("test decode and routing done");
    cmd(2'h2, 8'h55, 16'h0000, 2'h0, 1'b1, 2'h1);
    `CHK(crej[2], 1'b1)
    cmd(2'h3, `CCSH_CMD_NOP, 16'h0000, 2'h1, 1'b1, 2'h1);
    `CHK(crej[3], 1'b1)
    busy <= 4'h4;
    cmd(2'h2, `CCSH_CMD_NOP, 16'h0000, 2'h0, 1'b1, 2'h2);
    busy <= 4'h0; pend <= 4'h4;
    cmd(2'h2, `CCSH_CMD_TIO, 16'h0000, 2'h0, 1'b1, 2'h2);
    pend <= 4'h0; rdy <= 4'hB;
    cmd(2'h2, `CCSH_CMD_NOP, 16'h0000, 2'h0, 1'b1, 2'h1);
    cmd(2'h2, `CCSH_CMD_SENSE, 16'h0000, 2'h0, 1'b1, 2'h0);
    sreset(2'h2);
    `CHK(notify[2], 1'b0)
    rdy <= 4'hF;
    cmd(2'h1, `CCSH_CMD_NOP, 16'h0000, 2'h2, 1'b1, 2'h0);
    c0 = scnt;
    eirq <= 1'b1;
    @(posedge clk) eirq <= 1'b0;
    tick(3);
    `CHK({online, scnt}, {1'b1, c0})
    $display("test status answers done");
    sreset(2'h1);
    `CHK(notify[1], 1'b1)
    cmd(2'h1, `CCSH_CMD_NOP, 16'h0000, 2'h0, 1'b0, 2'h0);
    ack <= 4'h2;
    tick(2);
    ack <= 4'h0;
    tick(1);
    `CHK(notify[1], 1'b0)
    cmd(2'h1, `CCSH_CMD_NOP, 16'h0000, 2'h0, 1'b1, 2'h0);
    for (k = 0; k < 3; k++) begin
      xth <= (k == 0); ereg <= (k == 1) ? 7'h02 : 7'h01; xerr <= 1'b1;
      @(posedge clk) xerr <= 1'b0;
      tick(2);
      apb(1'b0, `CCSH_REG_ERR, 32'h0);
      `CHK(rdata[2:0], 3'h1 << k)
      `CHK(online, 1'b1)
      `CHK(lstat[2], 1'b1)
    end
    $display("test reset and errors done");
    dis <= 1'b1;
    tick(5);
    dis <= 1'b0;
    tick(3);
    `CHK(online, 1'b1)
    dis <= 1'b1;
    tick(30);
    `CHK(online, 1'b0)
    cmd(2'h1, `CCSH_CMD_NOP, 16'h0000, 2'h0, 1'b0, 2'h0);
    dis <= 1'b0;
    rst();
    for (k = 0; k < 20; k++) begin
      if (k == 19) `CHK(online, 1'b1)
      apar <= 1'b1;
      @(posedge clk) apar <= 1'b0;
      tick(1);
    end
    tick(3);
    `CHK(online, 1'b0)
    cmd(2'h1, `CCSH_CMD_NOP, 16'h0000, 2'h0, 1'b0, 2'h0);
    apb(1'b0, `CCSH_REG_RETRY, 32'h0);
    `CHK(rdata, 32'h0000_0014)
    apb(1'b1, `CCSH_REG_CTRL, 32'h0000_0001);
    tick(2);
    `CHK(online, 1'b1)
    apb(1'b0, 12'h020, 32'h0);
    `CHK(rerr, 1'b1)
    $display("test off-line paths done");
    stop_test();
  end
endmodule
`default_nettype wire
